// ---- drc_host_model.sv ----
// Host adapter model: drives chip selects, address, strobes, DMACK and data.
// Assumes one ref_clk domain; every phase is held at least 3 clocks.
`timescale 1ns/100ps
`default_nettype none
module drc_host_model (
    input wire logic ref_clk,
    input wire logic [15:0] dd_out,
    input wire logic dd_oe,
    output logic cs0_n,
    output logic cs1_n,
    output logic [2:0] da,
    output logic dior_n,
    output logic diow_n,
    output logic dmack_n,
    output logic [15:0] dd_in
);
    initial begin
        cs0_n = 1'h1;
        cs1_n = 1'h1;
        da = 3'h0;
        dior_n = 1'h1;
        diow_n = 1'h1;
        dmack_n = 1'h1;
        dd_in = 16'hA5C3;
    end
    // One strobe cycle; select and address stay put around the strobe
    task automatic cyc(input logic c0, input logic c1, input logic [2:0] a, input logic wr, input logic dma,
        input logic [15:0] d, output logic oe, output logic [15:0] q);
        @(posedge ref_clk);
        cs0_n <= c0;
        cs1_n <= c1;
        da <= a;
        dmack_n <= !dma;
        if (wr) begin
            dd_in <= d;
        end
        repeat (3) @(posedge ref_clk);
        if (wr) begin
            diow_n <= 1'h0;
        end else begin
            dior_n <= 1'h0;
        end
        repeat (6) @(posedge ref_clk);
        oe = dd_oe;
        q = dd_out;
        diow_n <= 1'h1;
        dior_n <= 1'h1;
        repeat (5) @(posedge ref_clk);
        cs0_n <= 1'h1;
        cs1_n <= 1'h1;
        dmack_n <= 1'h1;
        dd_in <= ~dd_in;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ---- drc_monitor.sv ----
// Checker on the decoder's top-level ports.
// Assumes bind into drc_top; single ref_clk domain.
`timescale 1ns/100ps
`default_nettype none
module drc_monitor
    import drc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic dmack_n,
    input wire logic dd_oe,
    input wire logic dmarq_out,
    input wire logic dmarq_oe,
    input wire logic soft_reset,
    input wire logic int_disable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_access;
        apb_setup ##1 psel && penable;
    endsequence
    rd_drive_start_a: assert property ($rose(dd_oe) |-> !$past(dior_n) && !$past(dior_n, 2))
        else $error("data bus driven without a read strobe");
    rd_drive_end_a: assert property ($fell(dd_oe) |-> $past(dior_n) && $past(dior_n, 2))
        else $error("data bus released while read strobe low");
    rd_selected_a: assert property (dd_oe && !$past(dmack_n, 3) |-> dmarq_oe)
        else $error("read answered under DMA acknowledge while not selected");
    dmarq_rel_a: assert property (dmarq_out |-> dmarq_oe)
        else $error("request asserted while released");
    ctl_write_a: assert property ($changed(int_disable) || $changed(soft_reset) |->
        $past(cs0_n, 2) && !$past(cs1_n, 2) && $past(da, 2) == DRC_DA_ALTCTL && $past(diow_n, 2))
        else $error("control bits changed without control write");
    apb_wait_a: assert property (apb_access |-> ##1 pready)
        else $error("ready not on second access cycle");
    apb_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    apb_err_a: assert property (pslverr |-> pready && psel && penable)
        else $error("error outside completion");
endmodule
bind drc_top drc_monitor drc_monitor_inst (.ref_clk, .reset_n, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dmack_n, .dd_oe,
    .dmarq_out, .dmarq_oe, .soft_reset, .int_disable, .psel, .penable, .pready, .pslverr);
`default_nettype wire

// ---- drc_pkg.sv ----
// Constants for the host register cycle decoder: pin codes, bit positions,
// reset values and the map of the APB-side control registers.
// Assumes a 32-bit APB slave with byte addresses in paddr.
package drc_pkg;

    // Address lines DA2..DA0 within the command block
    localparam logic [2:0] DRC_DA_DATA = 3'h0;
    localparam logic [2:0] DRC_DA_ERRFEAT = 3'h1;
    localparam logic [2:0] DRC_DA_SECCNT = 3'h2;
    localparam logic [2:0] DRC_DA_LBALO = 3'h3;
    localparam logic [2:0] DRC_DA_LBAMID = 3'h4;
    localparam logic [2:0] DRC_DA_LBAHI = 3'h5;
    localparam logic [2:0] DRC_DA_DEVICE = 3'h6;
    localparam logic [2:0] DRC_DA_STATCMD = 3'h7;
    // Control block: Alternate Status / Device Control
    localparam logic [2:0] DRC_DA_ALTCTL = 3'h6;

    // Bit positions
    localparam int DRC_DEV_BIT = 4;
    localparam int DRC_BSY_BIT = 7;
    localparam int DRC_DRQ_BIT = 3;
    localparam int DRC_NIEN_BIT = 1;
    localparam int DRC_SRST_BIT = 2;
    localparam int DRC_CTL_SLEEP = 0;
    localparam int DRC_CTL_PACKET = 1;
    localparam int DRC_CTL_DEVNUM = 2;
    localparam int DRC_CTL_STANDIN = 3;
    localparam int DRC_CTL_MWDMA = 4;
    localparam int DRC_CTL_DMAREQ = 5;
    localparam int DRC_EV_CMD = 0;
    localparam int DRC_EV_DIAG = 1;
    localparam int DRC_EV_DWR = 2;
    localparam int DRC_EV_DRD = 3;
    localparam int DRC_EV_DEVCTL = 4;

    // Opcode that an unselected device still acts on
    localparam logic [7:0] DRC_OP_DIAG = 8'h90;

    // Reset values
    localparam logic [7:0] DRC_BYTE_RST = 8'h00;
    localparam logic [15:0] DRC_WORD_RST = 16'h0000;
    localparam logic [5:0] DRC_CTL_RST = 6'h00;
    localparam logic [4:0] DRC_EV_RST = 5'h00;

    // APB register byte offsets
    localparam logic [7:0] DRC_A_CTRL = 8'h00;
    localparam logic [7:0] DRC_A_STATUS = 8'h04;
    localparam logic [7:0] DRC_A_ERROR = 8'h08;
    localparam logic [7:0] DRC_A_TF0 = 8'h0C;
    localparam logic [7:0] DRC_A_TF1 = 8'h10;
    localparam logic [7:0] DRC_A_EVENTS = 8'h14;
    localparam logic [7:0] DRC_A_PKT = 8'h18;
    localparam logic [7:0] DRC_A_DATA = 8'h1C;

endpackage

// ---- drc_sync.sv ----
// Two-flop synchroniser for the host-side pins.
// Assumes the inputs are asynchronous to ref_clk.
`timescale 1ns/100ps
`default_nettype none
module drc_sync #(
    parameter int W = 1
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] rst_val,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync_out;

    always_comb begin
        next_stage1 = reset_n ? async_in : rst_val;
        next_sync_out = reset_n ? stage1 : rst_val;
    end

    always_ff @(posedge ref_clk) begin
        stage1 <= next_stage1;
        sync_out <= next_sync_out;
    end
endmodule
`default_nettype wire

// ---- drc_top.sv ----
// Device-side decoder for host register and data-port strobe cycles,
// with an APB slave through which device firmware sees the task file.
// Assumes host pins are asynchronous and held stable around each strobe.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - On each completed DIOW- strobe, and while each DIOR- strobe is asserted, decide from state and address how to respond.
// - In Sleep with DMACK- asserted ignore all strobes; otherwise Sleep handling applies.
// - Awake unselected device ignores strobes while DMACK- is asserted.
// - Selected exactly when the Device register DEV bit equals own device number.
// - Device 0 standing in for absent Device 1 ignores strobes under DMACK-.
// - Unselected: ignore no chip select, both selects, reads, and writes while busy.
// - Device Control write is taken unless DMACK- is asserted, and nIEN/SRST act at once.
// - Unselected, not busy: address 1 write loads Features.
// - Unselected, not busy: address 2 write loads Sector Count.
// - Unselected, not busy: addresses 3, 4, 5 load LBA Low, Mid, High.
// - Unselected, not busy: address 6 loads Device and selection follows new DEV.
// - Unselected, not busy: Command latched; only diagnostics opcode is acted on.
// - Reads see Error, Status, Alt Status where writes load Features, Command, Control.
// - PACKET set: Interrupt reason at Sector Count, byte count at LBA Mid/High.
// - Selected with DMACK- asserted: data transfer only in Multiword DMA.
// - Pins are asserted, negated, released or don't care; released means output enable off.
module drc_top
    import drc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic cs0_n,
    input wire logic cs1_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic dmack_n,
    input wire logic [15:0] dd_in,
    output logic [15:0] dd_out,
    output logic dd_oe,
    output logic dmarq_out,
    output logic dmarq_oe,
    output logic soft_reset,
    output logic int_disable,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // Synchronised pins: {cs0,cs1,da,dior,diow,dmack,dd}
    logic [23:0] pins_s;
    logic cs0_s, cs1_s, dior_s, diow_s, dmack_s;
    logic [2:0] da_s;
    logic [15:0] dd_s;

    drc_sync #(.W(24)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .rst_val(24'hFF0000 | 24'h3E0000),
        .async_in({cs0_n, cs1_n, da, dior_n, diow_n, dmack_n, dd_in}),
        .sync_out(pins_s)
    );
    assign {cs0_s, cs1_s, da_s, dior_s, diow_s, dmack_s, dd_s} = pins_s;

    // Task file and firmware state
    logic dior_q, diow_q, next_dior_q, next_diow_q;
    logic [7:0] feature, seccnt, lba_lo, lba_mid, lba_hi, device, command, devctl;
    logic [7:0] next_feature, next_seccnt, next_lba_lo, next_lba_mid, next_lba_hi;
    logic [7:0] next_device, next_command, next_devctl;
    logic [7:0] status, error, int_reason, next_status, next_error, next_int_reason;
    logic [5:0] ctrl, next_ctrl;
    logic [4:0] events, next_events, ev_set;
    logic [15:0] host_wdata, fw_rdata, next_host_wdata, next_fw_rdata;
    logic [15:0] next_dd_out;
    logic next_dd_oe, next_dmarq_out, next_dmarq_oe;

    // APB response state
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic commit;

    // Decode helpers
    logic sleep, selected, stand_in, answering, dmack_a, cmd_blk, ctl_blk, bsy, drq;
    logic end_wr, end_rd, rd_on, dma_xfer, devctl_hit;
    logic [7:0] rd_byte;

    always_comb begin
        sleep = ctrl[DRC_CTL_SLEEP];
        selected = (device[DRC_DEV_BIT] == ctrl[DRC_CTL_DEVNUM]);
        stand_in = ctrl[DRC_CTL_STANDIN] && !ctrl[DRC_CTL_DEVNUM] && device[DRC_DEV_BIT];
        answering = selected || stand_in;
        dmack_a = !dmack_s;
        cmd_blk = !cs0_s && cs1_s;
        ctl_blk = cs0_s && !cs1_s;
        devctl_hit = ctl_blk && (da_s == DRC_DA_ALTCTL);
        bsy = status[DRC_BSY_BIT];
        drq = status[DRC_DRQ_BIT];
        end_wr = diow_s && !diow_q;
        end_rd = dior_s && !dior_q;
        rd_on = !dior_s;
        dma_xfer = dmack_a && !sleep && selected && ctrl[DRC_CTL_MWDMA];
        commit = psel && penable && pready && pwrite;
    end

    // Byte presented on a register read
    always_comb begin
        rd_byte = DRC_BYTE_RST;
        if (ctl_blk) begin
            rd_byte = status;
        end else begin
            unique case (da_s)
                DRC_DA_DATA: rd_byte = fw_rdata[7:0];
                DRC_DA_ERRFEAT: rd_byte = error;
                DRC_DA_SECCNT: rd_byte = ctrl[DRC_CTL_PACKET] ? int_reason : seccnt;
                DRC_DA_LBALO: rd_byte = lba_lo;
                DRC_DA_LBAMID: rd_byte = lba_mid;
                DRC_DA_LBAHI: rd_byte = lba_hi;
                DRC_DA_DEVICE: rd_byte = device;
                DRC_DA_STATCMD: rd_byte = status;
            endcase
        end
    end

    always_comb begin
        next_dior_q = dior_s;
        next_diow_q = diow_s;
        next_feature = feature;
        next_seccnt = seccnt;
        next_lba_lo = lba_lo;
        next_lba_mid = lba_mid;
        next_lba_hi = lba_hi;
        next_device = device;
        next_command = command;
        next_devctl = devctl;
        next_status = status;
        next_error = error;
        next_int_reason = int_reason;
        next_ctrl = ctrl;
        next_host_wdata = host_wdata;
        next_fw_rdata = fw_rdata;
        ev_set = DRC_EV_RST;

        // Host write cycles, decided when DIOW- is negated
        if (end_wr) begin
            if (dmack_a) begin
                if (dma_xfer) begin
                    next_host_wdata = dd_s;
                    ev_set[DRC_EV_DWR] = 1'b1;
                end
                // Other strobes under DMACK- are ignored
            end else if (devctl_hit) begin
                next_devctl = dd_s[7:0];
                ev_set[DRC_EV_DEVCTL] = 1'b1;
            end else if (!sleep && cmd_blk && !bsy) begin
                unique case (da_s)
                    DRC_DA_DATA: begin
                        if (selected && drq) begin
                            next_host_wdata = dd_s;
                            ev_set[DRC_EV_DWR] = 1'b1;
                        end
                    end
                    DRC_DA_ERRFEAT: next_feature = dd_s[7:0];
                    DRC_DA_SECCNT: begin
                        if (!ctrl[DRC_CTL_PACKET] || !answering) begin
                            next_seccnt = dd_s[7:0];
                        end
                    end
                    DRC_DA_LBALO: next_lba_lo = dd_s[7:0];
                    DRC_DA_LBAMID: next_lba_mid = dd_s[7:0];
                    DRC_DA_LBAHI: next_lba_hi = dd_s[7:0];
                    DRC_DA_DEVICE: next_device = dd_s[7:0];
                    DRC_DA_STATCMD: begin
                        next_command = dd_s[7:0];
                        if (answering) begin
                            ev_set[DRC_EV_CMD] = 1'b1;
                        end else if (dd_s[7:0] == DRC_OP_DIAG) begin
                            ev_set[DRC_EV_DIAG] = 1'b1;
                        end
                    end
                endcase
            end
        end

        // Completed data-port reads ask firmware for the next word
        if (end_rd && (dma_xfer || (!dmack_a && !sleep && selected && cmd_blk && da_s == DRC_DA_DATA))) begin
            ev_set[DRC_EV_DRD] = 1'b1;
        end

        // Firmware writes over APB
        if (commit) begin
            unique case (paddr)
                DRC_A_CTRL: next_ctrl = pwdata[5:0];
                DRC_A_STATUS: next_status = pwdata[7:0];
                DRC_A_ERROR: next_error = pwdata[7:0];
                DRC_A_PKT: begin
                    next_int_reason = pwdata[7:0];
                    next_lba_mid = pwdata[15:8];
                    next_lba_hi = pwdata[23:16];
                end
                DRC_A_DATA: next_fw_rdata = pwdata[15:0];
                default: ;
            endcase
        end

        // Sticky events; a new event wins over its clear
        next_events = events;
        if (commit && paddr == DRC_A_EVENTS) begin
            next_events = events & ~pwdata[4:0];
        end
        next_events = next_events | ev_set;

        // Host data bus drive while a read strobe is asserted
        next_dd_oe = 1'b0;
        next_dd_out = DRC_WORD_RST;
        if (rd_on) begin
            if (dma_xfer) begin
                next_dd_oe = 1'b1;
                next_dd_out = fw_rdata;
            end else if (!dmack_a && !sleep && answering && (cmd_blk || devctl_hit)) begin
                next_dd_oe = 1'b1;
                next_dd_out = (cmd_blk && da_s == DRC_DA_DATA) ? fw_rdata : {8'h00, rd_byte};
            end
        end

        // DMARQ is driven only by the selected device
        next_dmarq_oe = selected && !sleep;
        next_dmarq_out = selected && !sleep && ctrl[DRC_CTL_DMAREQ];
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dior_q <= 1'b1;
            diow_q <= 1'b1;
            feature <= DRC_BYTE_RST;
            seccnt <= DRC_BYTE_RST;
            lba_lo <= DRC_BYTE_RST;
            lba_mid <= DRC_BYTE_RST;
            lba_hi <= DRC_BYTE_RST;
            device <= DRC_BYTE_RST;
            command <= DRC_BYTE_RST;
            devctl <= DRC_BYTE_RST;
            status <= DRC_BYTE_RST;
            error <= DRC_BYTE_RST;
            int_reason <= DRC_BYTE_RST;
            ctrl <= DRC_CTL_RST;
            events <= DRC_EV_RST;
            host_wdata <= DRC_WORD_RST;
            fw_rdata <= DRC_WORD_RST;
            dd_out <= DRC_WORD_RST;
            dd_oe <= 1'b0;
            dmarq_out <= 1'b0;
            dmarq_oe <= 1'b0;
            soft_reset <= 1'b0;
            int_disable <= 1'b0;
        end else begin
            dior_q <= next_dior_q;
            diow_q <= next_diow_q;
            feature <= next_feature;
            seccnt <= next_seccnt;
            lba_lo <= next_lba_lo;
            lba_mid <= next_lba_mid;
            lba_hi <= next_lba_hi;
            device <= next_device;
            command <= next_command;
            devctl <= next_devctl;
            status <= next_status;
            error <= next_error;
            int_reason <= next_int_reason;
            ctrl <= next_ctrl;
            events <= next_events;
            host_wdata <= next_host_wdata;
            fw_rdata <= next_fw_rdata;
            dd_out <= next_dd_out;
            dd_oe <= next_dd_oe;
            dmarq_out <= next_dmarq_out;
            dmarq_oe <= next_dmarq_oe;
            soft_reset <= next_devctl[DRC_SRST_BIT];
            int_disable <= next_devctl[DRC_NIEN_BIT];
        end
    end

    // APB slave: one wait state, then pready with registered data
    always_comb begin
        next_pready = 1'b0;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        if (psel && penable && !pready) begin
            next_pready = 1'b1;
            next_prdata = 32'h00000000;
            unique case (paddr)
                DRC_A_CTRL: next_prdata = {26'h0000000, ctrl};
                DRC_A_STATUS: next_prdata = {24'h000000, status};
                DRC_A_ERROR: next_prdata = {24'h000000, error};
                DRC_A_TF0: next_prdata = {lba_mid, lba_lo, seccnt, feature};
                DRC_A_TF1: next_prdata = {devctl, command, device, lba_hi};
                DRC_A_EVENTS: next_prdata = {16'h0000, selected, 10'h000, events};
                DRC_A_PKT: next_prdata = {8'h00, lba_hi, lba_mid, int_reason};
                DRC_A_DATA: next_prdata = {fw_rdata, host_wdata};
                default: next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the host register cycle decoder.
// Assumes drc_top, drc_host_model and the bound checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import drc_pkg::*;
;
    logic ref_clk, reset_n, cs0_n, cs1_n, dior_n, diow_n, dmack_n, dd_oe, dmarq_out, dmarq_oe;
    logic soft_reset, int_disable, psel, penable, pwrite, pready, pslverr, oe;
    logic [2:0] da;
    logic [15:0] dd_in, dd_out, q;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    drc_top drc_top_inst (.ref_clk, .reset_n, .cs0_n, .cs1_n, .da, .dior_n, .diow_n, .dmack_n, .dd_in, .dd_out,
        .dd_oe, .dmarq_out, .dmarq_oe, .soft_reset, .int_disable, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    drc_host_model drc_host_model_inst (.ref_clk, .dd_out, .dd_oe, .cs0_n, .cs1_n, .da, .dior_n, .diow_n,
        .dmack_n, .dd_in);
    task automatic complete_run;
        if (error_cnt == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
        output logic err);
        @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'h1;
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 32'h0, r, e);
        chk(r & m, x);
    endtask
    task automatic hw(input logic [2:0] a, input logic [15:0] d);
        drc_host_model_inst.cyc(1'h0, 1'h1, a, 1'h1, 1'h0, d, oe, q);
    endtask
    task automatic hr(input logic alt, input logic dma, input logic [2:0] a, input logic [16:0] x);
        drc_host_model_inst.cyc(alt, !alt, a, 1'h0, dma, 16'h0, oe, q);
        chk({15'h0, oe, q}, {15'h0, x});
    endtask
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        chk({29'h0, dd_oe, pready, dmarq_oe}, 32'h1);
        wr(DRC_A_TF0, 32'hFFFFFFFF);
        rdc(DRC_A_TF0, 32'hFFFFFFFF, 32'h0);
        apb(1'h0, 8'h20, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
    endtask
    task automatic t_unsel;
        wr(DRC_A_CTRL, 32'h24);
        rdc(DRC_A_EVENTS, 32'h8000, 32'h0);
        chk({30'h0, dmarq_out, dmarq_oe}, 32'h0);
        for (int i = 1; i < 6; i++) begin
            hw(3'(i), 16'(i) * 16'h11);
        end
        rdc(DRC_A_TF0, 32'hFFFFFFFF, 32'h44332211);
        rdc(DRC_A_TF1, 32'hFF, 32'h55);
        hr(1'h0, 1'h0, DRC_DA_SECCNT, 17'h0);
        for (int i = 0; i < 4; i++) begin
            if (i == 3) begin
                wr(DRC_A_STATUS, 32'h80);
            end
            drc_host_model_inst.cyc(i == 0, i != 1, DRC_DA_ERRFEAT, 1'h1, i == 2, 16'hEE, oe, q);
        end
        rdc(DRC_A_TF0, 32'hFF, 32'h11);
        drc_host_model_inst.cyc(1'h1, 1'h0, DRC_DA_ALTCTL, 1'h1, 1'h0, 16'h06, oe, q);
        chk({30'h0, soft_reset, int_disable}, 32'h3);
        drc_host_model_inst.cyc(1'h1, 1'h0, DRC_DA_ALTCTL, 1'h1, 1'h0, 16'h00, oe, q);
        chk({30'h0, soft_reset, int_disable}, 32'h0);
        wr(DRC_A_STATUS, 32'h00);
    endtask
    task automatic t_cmd;
        wr(DRC_A_EVENTS, 32'hFFFF);
        hw(DRC_DA_STATCMD, 16'h20);
        rdc(DRC_A_TF1, 32'hFF0000, 32'h200000);
        rdc(DRC_A_EVENTS, 32'h2, 32'h0);
        hw(DRC_DA_STATCMD, 16'(DRC_OP_DIAG));
        rdc(DRC_A_EVENTS, 32'h2, 32'h2);
    endtask
    task automatic t_sel;
        hw(DRC_DA_DEVICE, 16'h10);
        chk({30'h0, dmarq_out, dmarq_oe}, 32'h3);
        rdc(DRC_A_EVENTS, 32'h8000, 32'h8000);
        wr(DRC_A_STATUS, 32'h50);
        wr(DRC_A_ERROR, 32'h0A);
        hr(1'h0, 1'h0, DRC_DA_STATCMD, 17'h10050);
        hr(1'h0, 1'h0, DRC_DA_ERRFEAT, 17'h1000A);
        hr(1'h1, 1'h0, DRC_DA_ALTCTL, 17'h10050);
        wr(DRC_A_CTRL, 32'h06);
        wr(DRC_A_PKT, 32'hBBAA03);
        hr(1'h0, 1'h0, DRC_DA_SECCNT, 17'h10003);
        hr(1'h0, 1'h0, DRC_DA_LBAMID, 17'h100AA);
        hr(1'h0, 1'h0, DRC_DA_LBAHI, 17'h100BB);
        wr(DRC_A_CTRL, 32'h14);
        wr(DRC_A_DATA, 32'h1234);
        hr(1'h0, 1'h1, DRC_DA_DATA, 17'h11234);
        drc_host_model_inst.cyc(1'h0, 1'h1, DRC_DA_DATA, 1'h1, 1'h1, 16'hBEEF, oe, q);
        rdc(DRC_A_DATA, 32'hFFFF, 32'hBEEF);
        rdc(DRC_A_EVENTS, 32'hC, 32'hC);
        wr(DRC_A_CTRL, 32'h15);
        drc_host_model_inst.cyc(1'h1, 1'h0, DRC_DA_ALTCTL, 1'h1, 1'h1, 16'h02, oe, q);
        chk({30'h0, int_disable, dmarq_oe}, 32'h0);
        drc_host_model_inst.cyc(1'h1, 1'h0, DRC_DA_ALTCTL, 1'h1, 1'h0, 16'h02, oe, q);
        chk({31'h0, int_disable}, 32'h1);
        wr(DRC_A_CTRL, 32'h08);
        hr(1'h0, 1'h0, DRC_DA_STATCMD, 17'h10050);
        chk({31'h0, dmarq_oe}, 32'h0);
        hr(1'h0, 1'h1, DRC_DA_STATCMD, 17'h0);
    endtask
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 3000) begin
            error_cnt++;
            complete_run();
        end
    end
    initial begin
        ref_clk = 1'h0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    initial begin
        reset_n = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (2) @(posedge ref_clk);
        t_reset();
        t_unsel();
        t_cmd();
        t_sel();
        complete_run();
    end
endmodule
`default_nettype wire
